// File: logic/frame_ctrl.sv
// Purpose: 802.15.4 frame sequencing, type filter, auto-ack and security flow
// Assumes: single-transfer AHB-Lite master; cipher engine outside
// Notes: buffers are flip-flops, one byte per bus word
//
// What this block does
// R1 - host trigger starts authenticate-and-encrypt of the transmit buffer frame
// R2 - on finish set encrypt-done flag, clear trigger; buffer holds result
// R3 - transmit-start sends the buffered frame and appends a computed FCS
// R4 - end of plain transmission raises transmit-complete and buffer-empty
// R5 - delimiter sets start-of-frame; if buffer full also overflow, no write
// R6 - after reception filter: rejected sets filtered, else receive-complete
// R7 - receive buffer keeps frame and FCS, then signal strength and quality
// R8 - writing one to decrypt trigger starts decrypt and tag check
// R9 - tag good sets decrypt-done, FCS then stale; bad sets tag-mismatch
// R10 - type field: beacon, data, ack, command; top bit set is reserved
// R11 - beacons are never parsed and always accepted
// R12 - filter bit 4 set rejects every data frame
// R13 - filter bit 5 set rejects every command frame
// R14 - auto-ack sends ack with same sequence, never via transmit buffer
// R15 - auto-ack only acts while frame check size setting is one
// R16 - command identifier byte is kept out of encryption
// R17 - security-enabled frames are parsed into security material both ways
// R18 - host loads beacon security material itself
// R19 - secured beacon senders must use frame version one; the frame version is not checked here
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`include "frame_ctrl_params.svh"

module frame_ctrl (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq,
	// receive stream from the radio
	input frame_ctrl_pkg::rx_in_s rx_in,
	// transmit stream to the radio
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// cipher engine
	output logic sec_start,
	output logic sec_decrypt,
	output frame_ctrl_pkg::sec_material_s sec_material,
	input wire logic sec_done,
	input wire logic sec_auth_ok,
	input frame_ctrl_pkg::sec_wb_s sec_wb
);

	// ------------------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------------------
	function automatic frame_ctrl_pkg::frame_kind_e kind_of(
		input logic [7:0] fc0);
		if (fc0[2]) begin
			kind_of = frame_ctrl_pkg::FK_RESERVED; // R10
		end else begin
			case (fc0[2:0])
				`FT_BEACON: kind_of = frame_ctrl_pkg::FK_BEACON;
				`FT_DATA: kind_of = frame_ctrl_pkg::FK_DATA;
				`FT_ACK: kind_of = frame_ctrl_pkg::FK_ACK;
				default: kind_of = frame_ctrl_pkg::FK_CMD;
			endcase
		end
	endfunction : kind_of

	function automatic logic [6:0] addr_len(input logic [1:0] mode);
		case (mode)
			`AM_SHORT: addr_len = `SHORT_LEN;
			`AM_LONG: addr_len = `LONG_LEN;
			default: addr_len = 7'h00;
		endcase
	endfunction : addr_len

	// mac_header length; auxiliary security header is left to the engine
	function automatic frame_ctrl_pkg::sec_material_s material_of(
		input logic [7:0] fc0, input logic [7:0] fc1);
		logic [6:0] len;
		logic src_pid;
		material_of = '0;
		len = `MHR_FIXED;
		src_pid = !(fc0[`FC_PIDCMP] && fc1[3]);
		if (kind_of(fc0) == frame_ctrl_pkg::FK_BEACON) begin
			material_of.host_loaded = 1'b1; // R11 R18
		end else if (fc0[`FC_SEC]) begin
			if (fc1[3:2] != 2'h0)
				len = len + `PID_LEN + addr_len(fc1[3:2]);
			if (fc1[7:6] != 2'h0 && src_pid)
				len = len + `PID_LEN;
			len = len + addr_len(fc1[7:6]);
			material_of.hdr_len = len; // R17
			material_of.pay_idx = len;
			if (kind_of(fc0) == frame_ctrl_pkg::FK_CMD)
				material_of.pay_idx = len + 7'h01; // R16
		end
	endfunction : material_of

	function automatic logic [15:0] crc_step(input logic [15:0] crc,
		input logic [7:0] d);
		logic [15:0] c;
		c = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		crc_step = c;
	endfunction : crc_step

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	frame_ctrl_pkg::state_s s;
	frame_ctrl_pkg::state_s next_s;

	logic [7:0] set_f;
	logic clr_flags;
	logic [7:0] src_len;
	logic [7:0] src_byte;
	logic [7:0] rx_fc0;
	logic reject;
	logic [6:0] wr_idx;
	logic ack_set;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign tx_valid = s.tx_valid;
	assign tx_data = s.tx_data;
	assign tx_last = s.tx_last;
	assign sec_start = s.sec_start;
	assign sec_decrypt = s.sec_dec;
	assign sec_material = s.material;
	// level follows the registered flags, so it is glitch free
	assign irq = |(s.flags & s.mask);

	// ------------------------------------------------------------------------
	// transmit byte source
	// ------------------------------------------------------------------------
	// ack frames come from constants, so the transmit buffer stays intact
	always_comb begin
		src_len = s.is_ack ? `ACK_LEN : s.tx_mem[`BUF_LEN_IDX];
		if (s.tx_pos + 8'h02 <= src_len) begin
			if (!s.is_ack)
				src_byte = s.tx_mem[s.tx_pos[6:0]];
			else if (s.tx_pos == 8'h00)
				src_byte = `ACK_LEN;
			else if (s.tx_pos == 8'h01)
				src_byte = `ACK_FC0;
			else if (s.tx_pos == 8'h02)
				src_byte = `ACK_FC1;
			else
				src_byte = s.ack_seq; // R14
		end else if (s.tx_pos + 8'h01 == src_len) begin
			src_byte = s.tx_crc[7:0];
		end else begin
			src_byte = s.tx_crc[15:8];
		end
	end

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		next_s = s;
		set_f = 8'h00;
		clr_flags = 1'b0;
		next_s.sec_start = 1'b0;
		rx_fc0 = s.rx_mem[`BUF_FC0_IDX];
		reject = 1'b0;
		wr_idx = s.dph_addr[8:2];
		ack_set = 1'b0;

		// --------------------------------------------------------
		// bus address phase; read data is registered here
		// --------------------------------------------------------
		next_s.dph_valid = hsel && htrans[1] && hready;
		next_s.dph_write = hwrite;
		next_s.dph_addr = haddr[11:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[11:0])
				`REG_CTRL: next_s.hrdata = {27'h0, s.ctrl};
				`REG_STATUS: begin
					next_s.hrdata = {24'h0, s.flags};
					clr_flags = 1'b1;
				end
				`REG_MASK: next_s.hrdata = {24'h0, s.mask};
				`REG_STATE: next_s.hrdata = {16'h0, 1'b0, s.rx_idx, 5'h0,
					s.fsm != frame_ctrl_pkg::ST_IDLE, s.rx_full,
					s.tx_empty};
				`REG_FILTER: next_s.hrdata = {24'h0, s.filter};
				default: begin
					if (haddr[11:9] == `BUF_SEL_TX)
						next_s.hrdata = {24'h0, s.tx_mem[haddr[8:2]]};
					else if (haddr[11:9] == `BUF_SEL_RX)
						next_s.hrdata = {24'h0, s.rx_mem[haddr[8:2]]};
					else
						next_s.hrdata = 32'h0;
				end
			endcase
		end

		// --------------------------------------------------------
		// receive path
		// --------------------------------------------------------
		if (rx_in.sfd) begin
			set_f[`FLG_SOF] = 1'b1; // R5
			next_s.rx_drop = s.rx_full;
			// a dropped frame leaves the held frame's length intact
			if (!s.rx_full)
				next_s.rx_idx = 7'h00; // R5
			if (s.rx_full)
				set_f[`FLG_RX_OVF] = 1'b1; // R5
		end else if (rx_in.valid && !s.rx_drop && !s.rx_full) begin
			next_s.rx_mem[s.rx_idx] = rx_in.data; // R7
			if (s.rx_idx < `RX_IDX_MAX)
				next_s.rx_idx = s.rx_idx + 7'h01;
		end else if (rx_in.done && !s.rx_drop && !s.rx_full) begin
			next_s.rx_mem[s.rx_idx] = rx_in.rssi; // R7
			next_s.rx_mem[s.rx_idx + 7'h01] = rx_in.lqi;
			case (kind_of(rx_fc0))
				frame_ctrl_pkg::FK_DATA:
					reject = s.filter[`FILT_DATA_REJ]; // R12
				frame_ctrl_pkg::FK_CMD:
					reject = s.filter[`FILT_CMD_REJ]; // R13
				default: reject = 1'b0; // R11
			endcase
			if (reject) begin
				set_f[`FLG_FILTERED] = 1'b1; // R6
			end else begin
				set_f[`FLG_RX_DONE] = 1'b1; // R6
				next_s.rx_full = 1'b1;
				if (s.ctrl[`CTRL_ACKEN] && s.ctrl[`CTRL_FCSZ]
					&& rx_fc0[`FC_ACKNOWLEDGE_REQUEST_BIT]
					&& kind_of(rx_fc0) != frame_ctrl_pkg::FK_ACK
					&& kind_of(rx_fc0) != frame_ctrl_pkg::FK_BEACON) begin
					next_s.ack_pend = 1'b1; // R14 R15
					next_s.ack_seq = s.rx_mem[`BUF_SEQ_IDX];
					ack_set = 1'b1;
				end
			end
		end

		// --------------------------------------------------------
		// sequencer
		// --------------------------------------------------------
		case (s.fsm)
			frame_ctrl_pkg::ST_IDLE: begin
				next_s.tx_pos = 8'h00;
				next_s.tx_crc = `CRC_INIT;
				next_s.tx_valid = 1'b0;
				next_s.tx_last = 1'b0;
				// ack first: the remote sender only waits so long
				if (s.ack_pend) begin
					next_s.is_ack = 1'b1;
					next_s.fsm = frame_ctrl_pkg::ST_SEND;
				end else if (s.ctrl[`CTRL_ENC]) begin
					next_s.sec_dec = 1'b0;
					next_s.sec_start = 1'b1; // R1
					next_s.material = material_of(s.tx_mem[`BUF_FC0_IDX],
						s.tx_mem[`BUF_FC1_IDX]);
					next_s.fsm = frame_ctrl_pkg::ST_SEC;
				end else if (s.ctrl[`CTRL_DEC]) begin
					next_s.sec_dec = 1'b1;
					next_s.sec_start = 1'b1; // R8
					next_s.material = material_of(rx_fc0,
						s.rx_mem[`BUF_FC1_IDX]);
					next_s.fsm = frame_ctrl_pkg::ST_SEC;
				end else if (s.ctrl[`CTRL_TRANSMIT_START]) begin
					next_s.is_ack = 1'b0;
					next_s.fsm = frame_ctrl_pkg::ST_SEND; // R3
				end
			end
			frame_ctrl_pkg::ST_SEC: begin
				// the engine rewrites the buffer it is working on
				if (sec_wb.valid && s.sec_dec)
					next_s.rx_mem[sec_wb.idx] = sec_wb.data;
				else if (sec_wb.valid)
					next_s.tx_mem[sec_wb.idx] = sec_wb.data; // R2
				if (sec_done) begin
					next_s.fsm = frame_ctrl_pkg::ST_IDLE;
					if (!s.sec_dec) begin
						set_f[`FLG_ENC_DONE] = 1'b1; // R2
						next_s.ctrl[`CTRL_ENC] = 1'b0;
					end else begin
						next_s.ctrl[`CTRL_DEC] = 1'b0;
						if (sec_auth_ok)
							set_f[`FLG_DEC_DONE] = 1'b1; // R9
						else
							set_f[`FLG_TAG_BAD] = 1'b1; // R9
					end
				end
			end
			frame_ctrl_pkg::ST_SEND: begin
				if (!s.tx_valid || tx_ready) begin
					if (s.tx_valid && s.tx_last) begin
						next_s.tx_valid = 1'b0;
						next_s.tx_last = 1'b0;
						next_s.fsm = frame_ctrl_pkg::ST_IDLE;
						if (s.is_ack) begin
							// a request landing now must not be lost
							next_s.ack_pend = ack_set;
						end else begin
							set_f[`FLG_TX_DONE] = 1'b1; // R4
							next_s.tx_empty = 1'b1; // R4
							next_s.ctrl[`CTRL_TRANSMIT_START] = 1'b0;
						end
					end else begin
						next_s.tx_data = src_byte;
						next_s.tx_valid = 1'b1;
						next_s.tx_last = (s.tx_pos == src_len);
						if (s.tx_pos != 8'h00
							&& s.tx_pos + 8'h02 <= src_len)
							next_s.tx_crc = crc_step(s.tx_crc,
								src_byte); // R3
						next_s.tx_pos = s.tx_pos + 8'h01;
					end
				end
			end
			default: next_s.fsm = frame_ctrl_pkg::ST_IDLE;
		endcase

		// --------------------------------------------------------
		// bus data phase; host writes come last so a trigger set wins
		// --------------------------------------------------------
		if (s.dph_valid && s.dph_write) begin
			case (s.dph_addr)
				`REG_CTRL: begin
					next_s.ctrl[`CTRL_ENC] = next_s.ctrl[`CTRL_ENC]
						| hwdata[`CTRL_ENC];
					next_s.ctrl[`CTRL_TRANSMIT_START] = next_s.ctrl[`CTRL_TRANSMIT_START]
						| hwdata[`CTRL_TRANSMIT_START];
					next_s.ctrl[`CTRL_DEC] = next_s.ctrl[`CTRL_DEC]
						| hwdata[`CTRL_DEC];
					next_s.ctrl[`CTRL_ACKEN] = hwdata[`CTRL_ACKEN];
					next_s.ctrl[`CTRL_FCSZ] = hwdata[`CTRL_FCSZ];
					// a frame completing in the same cycle keeps it full
					if (hwdata[`CTRL_RXREL])
						next_s.rx_full = set_f[`FLG_RX_DONE];
				end
				`REG_MASK: next_s.mask = hwdata[7:0];
				`REG_FILTER: next_s.filter = hwdata[7:0];
				default: begin
					if (s.dph_addr[11:9] == `BUF_SEL_TX) begin
						next_s.tx_mem[wr_idx] = hwdata[7:0];
						// the hardware set of empty wins a same-cycle write
						next_s.tx_empty = set_f[`FLG_TX_DONE];
					end
				end
			endcase
		end

		// a hardware event in the clearing read's cycle survives
		next_s.flags = (clr_flags ? 8'h00 : s.flags) | set_f;
	end

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '{fsm: frame_ctrl_pkg::ST_IDLE, filter: `FILTER_RESET,
				tx_empty: 1'b1, default: '0};
		else
			s <= next_s;
	end

endmodule : frame_ctrl

// File: logic/frame_ctrl_params.svh
// Purpose: offsets, bit positions, reset values and codes of the frame control
// Assumes: included by frame_ctrl
// Notes: byte addresses on a 32-bit AHB-Lite bus, one register per word
`ifndef FRAME_CTRL_PARAMS_SVH
`define FRAME_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_STATE 12'h00c
`define REG_FILTER 12'h018
`define BUF_SEL_TX 3'h1
`define BUF_SEL_RX 3'h2

// ----------------------------------------------------------------------------
// control bits
// ----------------------------------------------------------------------------
`define CTRL_ENC 0
`define CTRL_TRANSMIT_START 1
`define CTRL_DEC 2
`define CTRL_ACKEN 3
`define CTRL_FCSZ 4
`define CTRL_RXREL 5

// ----------------------------------------------------------------------------
// status and mask bits
// ----------------------------------------------------------------------------
`define FLG_ENC_DONE 0
`define FLG_TX_DONE 1
`define FLG_SOF 2
`define FLG_RX_OVF 3
`define FLG_FILTERED 4
`define FLG_RX_DONE 5
`define FLG_DEC_DONE 6
`define FLG_TAG_BAD 7

// ----------------------------------------------------------------------------
// receive filter
// ----------------------------------------------------------------------------
`define FILTER_RESET 8'h7f
`define FILT_DATA_REJ 4
`define FILT_CMD_REJ 5

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define FT_BEACON 3'h0
`define FT_DATA 3'h1
`define FT_ACK 3'h2
`define FT_CMD 3'h3
`define FC_SEC 3
`define FC_ACKNOWLEDGE_REQUEST_BIT 5
`define FC_PIDCMP 6
`define BUF_LEN_IDX 7'h00
`define BUF_FC0_IDX 7'h01
`define BUF_FC1_IDX 7'h02
`define BUF_SEQ_IDX 7'h03
`define AM_SHORT 2'h2
`define AM_LONG 2'h3
`define MHR_FIXED 7'h03
`define PID_LEN 7'h02
`define SHORT_LEN 7'h02
`define LONG_LEN 7'h08
`define ACK_LEN 8'h05
`define ACK_FC0 8'h02
`define ACK_FC1 8'h00
`define CRC_POLY 16'h8408
`define CRC_INIT 16'h0000
`define RX_IDX_MAX 7'h7d

`endif

// File: logic/frame_ctrl_pkg.sv
// Purpose: types shared by the frame control and its bench
// Assumes: frame_ctrl_params.svh for the figures
// Notes: one-hot sequencer states
package frame_ctrl_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEC = 3'b010,
		ST_SEND = 3'b100
	} seq_e;

	typedef enum logic [2:0] {
		FK_BEACON, FK_DATA, FK_ACK, FK_CMD, FK_RESERVED
	} frame_kind_e;

	typedef struct packed {
		logic [6:0] hdr_len;
		logic [6:0] pay_idx;
		logic host_loaded;
	} sec_material_s;

	typedef struct packed {
		logic sfd;
		logic valid;
		logic [7:0] data;
		logic done;
		logic [7:0] rssi;
		logic [7:0] lqi;
	} rx_in_s;

	typedef struct packed {
		logic valid;
		logic [6:0] idx;
		logic [7:0] data;
	} sec_wb_s;

	typedef struct packed {
		seq_e fsm;
		logic [4:0] ctrl;
		logic [7:0] filter;
		logic [7:0] flags;
		logic [7:0] mask;
		logic tx_empty;
		logic rx_full;
		logic rx_drop;
		logic [6:0] rx_idx;
		logic sec_dec;
		logic sec_start;
		sec_material_s material;
		logic is_ack;
		logic ack_pend;
		logic [7:0] ack_seq;
		logic [7:0] tx_pos;
		logic [15:0] tx_crc;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_last;
		logic dph_valid;
		logic dph_write;
		logic [11:0] dph_addr;
		logic [31:0] hrdata;
		logic [127:0][7:0] tx_mem;
		logic [127:0][7:0] rx_mem;
	} state_s;

endpackage : frame_ctrl_pkg

// File: verif/frame_ctrl_sva.sv
// Purpose: port assertions of frame_ctrl
// Assumes: one clock, hready tied to hreadyout
// Notes: attached by the bind at the foot
`timescale 1ns/10ps
module frame_ctrl_sva (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// register bus
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [31:0] hwdata,
	input logic hready,
	input logic hreadyout,
	input logic irq,
	// streams
	input frame_ctrl_pkg::rx_in_s rx_in,
	input logic tx_valid,
	input logic [7:0] tx_data,
	input logic tx_last,
	input logic tx_ready,
	input logic sec_start,
	input logic sec_decrypt,
	input logic sec_done
);
	// --------
	// control write data phase
	// --------
	logic take, ph_ctrl;
	assign take = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ph_ctrl <= 1'b0;
		else
			ph_ctrl <= take && hwrite && haddr[11:0] == 12'h000;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout dropped");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("tx byte changed before accept");
	a_start_pulse: assert property (sec_start |=> !sec_start)
		else $error("sec_start longer than one cycle");
	a_last_valid: assert property (tx_last |-> tx_valid)
		else $error("tx_last without tx_valid");
	a_tx_soon: assert property (ph_ctrl && hwdata[1] |->
		##[1:4] tx_valid) else $error("transmit did not start");
	a_enc_soon: assert property (ph_ctrl && hwdata[0] |->
		##[1:4] sec_start && !sec_decrypt)
		else $error("encrypt did not start");
	a_dec_soon: assert property (ph_ctrl && hwdata[2] |->
		##[1:4] sec_start && sec_decrypt)
		else $error("decrypt did not start");
	// events landing with the read may set a flag again
	a_read_clears: assert property (take && !hwrite &&
		haddr[11:0] == 12'h004 && !sec_done && !$past(sec_done) &&
		!rx_in.sfd && !rx_in.done && !tx_valid |=> !irq)
		else $error("irq stayed up after status read");
	c_tx_end: cover property (tx_valid && tx_ready && tx_last);
	c_decrypt: cover property (sec_start && sec_decrypt);
	c_irq: cover property (irq);
endmodule : frame_ctrl_sva

bind frame_ctrl frame_ctrl_sva i_sva (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .irq, .rx_in,
	.tx_valid, .tx_data, .tx_last, .tx_ready, .sec_start, .sec_decrypt,
	.sec_done);

// File: verif/radio_model.sv
// Purpose: radio sink and cipher engine beside frame_ctrl
// Assumes: engine answers every start after a fixed delay
// Notes: sec_wb data wanders while not valid
`timescale 1ns/10ps
module radio_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// test controls
	input wire logic slow,
	input wire logic auth_good,
	// transmit stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// cipher engine
	input wire logic sec_start,
	output logic sec_done,
	output logic sec_auth_ok,
	output frame_ctrl_pkg::sec_wb_s sec_wb
);
	logic [7:0] got [$];
	logic [1:0] cnt;
	int t;
	// --------
	// stalls, sink and cipher
	// --------
	assign tx_ready = !slow || cnt == 2'h0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 2'h0;
			t <= 0;
			sec_done <= 1'b0;
			sec_auth_ok <= 1'b0;
			sec_wb <= '0;
		end else begin
			cnt <= cnt + 2'h1;
			if (tx_valid && tx_ready)
				got.push_back(tx_data);
			t <= sec_start ? 6 : (t > 0 ? t - 1 : 0);
			sec_done <= t == 1;
			// auth level is only meaningful with done
			sec_auth_ok <= (t == 1) ? auth_good : !auth_good;
			sec_wb.valid <= t == 3;
			sec_wb.idx <= 7'h04;
			sec_wb.data <= (t == 3) ? 8'h46 : ~sec_wb.data;
		end
	end
endmodule : radio_model

// File: verif/tb_top.sv
// Purpose: self-checking bench of frame_ctrl
// Assumes: radio_model stands in for radio and cipher
// Notes: bus tasks wait on hreadyout under a bound
`timescale 1ns/10ps
module tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, s;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq, tx_valid, tx_last, tx_ready;
	logic sec_start, sec_decrypt, sec_done, sec_auth_ok;
	logic slow = 1'b0, auth_good = 1'b1;
	logic [7:0] tx_data;
	logic [7:0] q [$];
	frame_ctrl_pkg::rx_in_s rx_in = '0;
	frame_ctrl_pkg::sec_material_s sec_material;
	frame_ctrl_pkg::sec_wb_s sec_wb;
	int n_fail = 0, total_checks = 0;

	frame_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.irq, .rx_in, .tx_valid, .tx_data, .tx_last, .tx_ready, .sec_start,
		.sec_decrypt, .sec_material, .sec_done, .sec_auth_ok, .sec_wb);
	radio_model i_partner (.hclk, .hresetn, .slow, .auth_good, .tx_valid,
		.tx_data, .tx_ready, .sec_start, .sec_done, .sec_auth_ok, .sec_wb);

	// --------
	// shared tasks
	// --------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task bound(input logic ok);
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: wait ran out", $time);
			tally_and_finish();
		end
	endtask : bound
	task ready_edge;
		int n;
		n = 0;
		@(posedge hclk);
		for (n = 0; n < 50 && hreadyout !== 1'b1; n++)
			@(posedge hclk);
		bound(hreadyout === 1'b1);
	endtask : ready_edge
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		ready_edge();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		ready_edge();
		r = hrdata;
	endtask : bus
	task wait_start;
		int n;
		for (n = 0; n < 20 && sec_start !== 1'b1; n++)
			@(posedge hclk);
		bound(sec_start === 1'b1);
	endtask : wait_start
	task poll(input logic [7:0] m);
		int n;
		r = 32'h0;
		for (n = 0; n < 30 && (r[7:0] & m) == 8'h0; n++)
			bus(1'b0, 12'h004, 32'h0);
		bound((r[7:0] & m) != 8'h0);
	endtask : poll
	function automatic logic [15:0] crc16(input logic [7:0] b [$]);
		logic [15:0] c;
		c = 16'h0;
		foreach (b[i]) begin
			c = c ^ {8'h0, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return c;
	endfunction : crc16
	task expect_tx;
		logic [15:0] c;
		int n;
		c = crc16(q[1:$]);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		for (n = 0; n < 200 && i_partner.got.size() < q.size(); n++)
			@(posedge hclk);
		bound(i_partner.got.size() == q.size());
		foreach (q[i])
			chk(i_partner.got[i], q[i]);
	endtask : expect_tx
	task rx_send(input logic [7:0] b [$]);
		@(posedge hclk);
		rx_in <= {1'b1, 26'h0};
		foreach (b[i]) begin
			@(posedge hclk);
			rx_in <= {2'b01, b[i], 17'h0};
		end
		@(posedge hclk);
		rx_in <= {10'h0, 1'b1, 16'h6c42};
		@(posedge hclk);
		rx_in <= '0;
		repeat (3) @(posedge hclk);
	endtask : rx_send

	// --------
	// scenarios
	// --------
	task t_reset;
		bus(1'b0, 12'h018, 32'h0);
		chk(r, 32'h7f);
		chk(hresp, 1'b0);
		bus(1'b0, 12'h00c, 32'h0);
		chk(r, 32'h1);
		bus(1'b0, 12'h100, 32'h0);
		chk(r, 32'h0);
		bus(1'b1, 12'h018, 32'h45);
		bus(1'b0, 12'h018, 32'h0);
		chk(r, 32'h45);
	endtask : t_reset
	task t_transmit;
		q = '{8'h05, 8'h41, 8'h88, 8'h7a};
		foreach (q[i])
			bus(1'b1, 12'h200 + 12'(4 * i), {24'h0, q[i]});
		slow <= 1'b1;
		bus(1'b1, 12'h000, 32'h2);
		expect_tx();
		bus(1'b0, 12'h004, 32'h0);
		chk(r, 32'h2);
		bus(1'b0, 12'h00c, 32'h0);
		chk(r[0], 1'b1);
	endtask : t_transmit
	task t_encrypt(input logic [7:0] fc0, input logic [7:0] fc1);
		bus(1'b1, 12'h204, {24'h0, fc0});
		bus(1'b1, 12'h208, {24'h0, fc1});
		bus(1'b1, 12'h000, 32'h1);
		wait_start();
		chk(sec_decrypt, 1'b0);
		if (fc0[2:0] == 3'h0)
			chk(sec_material.host_loaded, 1'b1);
		else begin
			chk(sec_material.hdr_len, 7'h0b);
			chk(sec_material.pay_idx, 7'h0c);
		end
		poll(8'h01);
		bus(1'b0, 12'h000, 32'h0);
		chk(r[0], 1'b0);
		bus(1'b0, 12'h210, 32'h0);
		chk(r, 32'h46);
	endtask : t_encrypt
	task t_filter;
		logic rej;
		for (int f = 0; f < 2; f++) begin
			bus(1'b1, 12'h018, f ? 32'h30 : 32'h00);
			for (int t = 0; t < 8; t++) begin
				rej = f && (t == 1 || t == 3);
				rx_send('{8'h05, 8'(t), 8'h00, 8'h11});
				bus(1'b0, 12'h004, 32'h0);
				chk(r, rej ? 32'h14 : 32'h24);
				bus(1'b1, 12'h000, 32'h20);
			end
		end
		bus(1'b1, 12'h018, 32'h0);
	endtask : t_filter
	task t_hold;
		q = '{8'h06, 8'h01, 8'h00, 8'h33, 8'hff, 8'h6c, 8'h42};
		rx_send(q[0:4]);
		bus(1'b0, 12'h004, 32'h0);
		chk(r, 32'h24);
		foreach (q[i]) begin
			bus(1'b0, 12'h400 + 12'(4 * i), 32'h0);
			chk(r, {24'h0, q[i]});
		end
		bus(1'b0, 12'h00c, 32'h0);
		s = r;
		rx_send('{8'h05, 8'h03, 8'h00, 8'h44});
		bus(1'b0, 12'h004, 32'h0);
		chk(r, 32'h0c);
		bus(1'b0, 12'h404, 32'h0);
		chk(r, 32'h01);
		bus(1'b0, 12'h00c, 32'h0);
		chk(r[14:8], s[14:8]);
		for (int a = 1; a >= 0; a--) begin
			auth_good <= 1'(a);
			bus(1'b1, 12'h000, 32'h4);
			wait_start();
			chk(sec_decrypt, 1'b1);
			poll(8'hc0);
			chk(r[7:6], a ? 2'b01 : 2'b10);
		end
		bus(1'b0, 12'h410, 32'h0);
		chk(r, 32'h46);
		bus(1'b1, 12'h000, 32'h20);
	endtask : t_hold
	task t_autoack;
		bus(1'b1, 12'h000, 32'h18);
		i_partner.got.delete();
		slow <= 1'b0;
		rx_send('{8'h05, 8'h21, 8'h00, 8'h5a});
		q = '{8'h05, 8'h02, 8'h00, 8'h5a};
		expect_tx();
		bus(1'b0, 12'h004, 32'h0);
		chk(r, 32'h24);
		bus(1'b0, 12'h204, 32'h0);
		chk(r, 32'h0b);
		bus(1'b1, 12'h000, 32'h28);
		i_partner.got.delete();
		rx_send('{8'h05, 8'h21, 8'h00, 8'h5b});
		repeat (40) @(posedge hclk);
		chk(i_partner.got.size(), 32'h0);
		bus(1'b1, 12'h000, 32'h20);
	endtask : t_autoack
	task t_irq;
		bus(1'b1, 12'h008, 32'h20);
		rx_send('{8'h05, 8'h01, 8'h00, 8'h66});
		chk(irq, 1'b1);
		bus(1'b1, 12'h008, 32'h00);
		#1;
		chk(irq, 1'b0);
		bus(1'b1, 12'h008, 32'h20);
		#1;
		chk(irq, 1'b1);
		bus(1'b0, 12'h004, 32'h0);
		chk(irq, 1'b0);
		bus(1'b1, 12'h000, 32'h20);
	endtask : t_irq

	initial forever #25 hclk = ~hclk;
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_transmit();
		t_encrypt(8'h08, 8'h10);
		t_encrypt(8'h0b, 8'h88);
		t_filter();
		t_hold();
		t_autoack();
		t_irq();
		tally_and_finish();
	end
endmodule : tb_top
